// *** ext_bus_pkg.sv ***
/*
 Package for the external bus chip-select assignment and pin multiplexer.
 Holds the register offset, field positions, reset value and bus widths.
 Assumes an APB master and one clock domain.
*/
// Function
// - Chip select 1 bit selects static controller at 0, DRAM controller at 1.
// - Chip select 3 stays static; bit 1 turns on NAND support logic.
// - Chip select 4 stays static; bit 1 turns on card slot 1 logic.
// - Chip select 5 stays static; bit 1 turns on card slot 2 logic.
// - Pull-up bit 0 enables data pull-ups on D15..D0, 1 disables them.
// - Voltage bit 0 means 1.8V memories, 1 means 3.3V, output to I/O.
// - Assignment register resets to 0x00010000.
// - Bus offers 32-bit data, 26 address lines, eight active-low chip selects.
// - Shared pins follow the DRAM controller while it is active and owns chip select 1, else the static controller.
// - Address pins 11..2 carry DRAM bits 9..0 or static bits 11..2.
// - DRAM address-10 pin carries DRAM bit 10; pins 14..13 DRAM 12..11 or static.
// - Address pins 0 and 1 are driven only by the static controller.
// - Address pin 12 and pins 25..15 come only from the static controller.
// - Write-1 pin carries DRAM byte mask 1 or static write strobe 1.
// - Bus serves up to eight external devices in their own address spaces.
package ext_bus_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] CSA_OFFSET = 12'h11C;
    localparam logic [31:0] CSA_RESET = 32'h00010000;
    localparam logic [31:0] CSA_MASK = 32'h0001013A;
    localparam int CS1_BIT = 1;
    localparam int CS3_BIT = 3;
    localparam int CS4_BIT = 4;
    localparam int CS5_BIT = 5;
    localparam int PULLUP_BIT = 8;
    localparam int VSEL_BIT = 16;

    // ----------------------------------------
    // Bus widths
    // ----------------------------------------
    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int NCS_W = 8;
    localparam int DRAM_ADDR_W = 13;
    localparam int CS1_IDX = 1;
    localparam int CS3_IDX = 3;
    localparam int CS4_IDX = 4;
    localparam int CS5_IDX = 5;
    localparam logic [31:0] ZERO32 = 32'h00000000;

endpackage : ext_bus_pkg

// *** csa_apb_regs.sv ***
/*
 APB slave holding the chip-select assignment register.
 Assumes a 32-bit APB master on the same clock; answers with no wait state.
*/
module csa_apb_regs
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pslverr,
    // Register value
    output logic [31:0] csa
);

    typedef struct packed
    {
        logic [31:0] csa;
        logic [31:0] rdata;
        logic err;
    } regs_s;

    regs_s q, d;

    always_comb
    begin
        d = q;
        if (psel && !penable)
        begin
            d.err = (paddr != ext_bus_pkg::CSA_OFFSET);
            d.rdata = (paddr == ext_bus_pkg::CSA_OFFSET) ? q.csa : ext_bus_pkg::ZERO32;
        end
        if (psel && penable && pwrite && paddr == ext_bus_pkg::CSA_OFFSET)
        begin
            // Only implemented bits store; reserved bits stay zero.
            d.csa = pwdata & ext_bus_pkg::CSA_MASK;
            d.rdata = ext_bus_pkg::ZERO32;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            q.csa <= ext_bus_pkg::CSA_RESET;
            q.rdata <= ext_bus_pkg::ZERO32;
            q.err <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign csa = q.csa;
    assign prdata = q.rdata;
    assign pslverr = q.err;

    a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
        (q.csa & ~ext_bus_pkg::CSA_MASK) == ext_bus_pkg::ZERO32) else $error("reserved bit set");
    a_write_lands: assert property (@(posedge MCLK) disable iff (!RSTN)
        psel && penable && pwrite && paddr == ext_bus_pkg::CSA_OFFSET
        |=> q.csa == ($past(pwdata) & ext_bus_pkg::CSA_MASK)) else $error("write lost");
    c_write: cover property (@(posedge MCLK) psel && penable && pwrite);

endmodule : csa_apb_regs

// *** ext_pin_route.sv ***
/*
 Combinational routing of controller address and strobe lines onto shared pins.
 Assumes the owning-controller select is stable for the whole access.
*/
module ext_pin_route
(
    // Controller select
    input wire logic dram_active,
    // Static controller
    input wire logic [25:0] smc_addr,
    input wire logic write_strobe1_n_in,
    // DRAM controller
    input wire logic [12:0] dram_addr,
    input wire logic dram_byte_mask1_n,
    // Pins
    output logic [25:0] pin_addr,
    output logic pin_a10,
    output logic pin_wr1_n
);

    always_comb
    begin
        pin_addr = smc_addr;
        pin_a10 = 1'b0;
        pin_wr1_n = write_strobe1_n_in;
        if (dram_active)
        begin
            pin_addr[11:2] = dram_addr[9:0];
            pin_addr[14:13] = dram_addr[12:11];
            pin_a10 = dram_addr[10];
            pin_wr1_n = dram_byte_mask1_n;
        end
    end

endmodule : ext_pin_route

// *** ext_bus_cs_assign_pin_mux.sv ***
/*
 Top of the external bus chip-select assignment and pin multiplexer.
 Holds the configuration register behind APB and routes the static and DRAM
 controller lines to the shared pins. Assumes both controllers run on MCLK.
*/
// Decided for this implementation: the APB register port.
module ext_bus_cs_assign_pin_mux
#(
    parameter int ADDR_W = ext_bus_pkg::ADDR_W,
    parameter int NCS_W = ext_bus_pkg::NCS_W
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Static controller side
    input wire logic [ADDR_W-1:0] SMC_ADDR,
    input wire logic [NCS_W-1:0] SMC_CS_N,
    input wire logic SMC_WRITE_STROBE1_N,
    input wire logic SMC_ACTIVE,
    // DRAM controller side
    input wire logic [12:0] DRAM_ADDR,
    input wire logic DRAM_CS_N,
    input wire logic DRAM_BYTE_MASK1_N,
    input wire logic DRAM_ACTIVE,
    input wire logic DRAM_CLOCK_ENABLE_IN,
    // External pins
    input wire logic EXTERNAL_WAIT_N,
    output logic [ADDR_W-1:0] ADDR_PINS,
    output logic DRAM_ADDRESS10_PIN,
    output logic WRITE_STROBE1_N,
    output logic [NCS_W-1:0] CHIP_SELECT_LINES_N,
    output logic DRAM_CLOCK_ENABLE,
    output logic WAIT_TO_SMC_N,
    // Configuration outputs
    output logic CS3_NAND_LOGIC_ENABLE,
    output logic CS4_CARD_SLOT1_ENABLE,
    output logic CS5_CARD_SLOT2_ENABLE,
    output logic DATA_PULLUP_ENABLE,
    output logic MEMORY_VOLTAGE_SELECT
);

    logic [31:0] csa;
    logic [25:0] route_addr;
    logic route_a10;
    logic route_wr1_n;
    logic dram_owns;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    csa_apb_regs u_regs
    (
        .MCLK(MCLK),
        .RSTN(RSTN),
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .paddr(PADDR),
        .pwdata(PWDATA),
        .prdata(),
        .pslverr(),
        .csa(csa)
    );

    // DRAM may drive the shared pins only while it owns chip select 1.
    assign dram_owns = DRAM_ACTIVE && csa[ext_bus_pkg::CS1_BIT];

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    ext_pin_route u_route
    (
        .dram_active(dram_owns),
        .smc_addr(SMC_ADDR[25:0]),
        .write_strobe1_n_in(SMC_WRITE_STROBE1_N),
        .dram_addr(DRAM_ADDR),
        .dram_byte_mask1_n(DRAM_BYTE_MASK1_N),
        .pin_addr(route_addr),
        .pin_a10(route_a10),
        .pin_wr1_n(route_wr1_n)
    );

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic a10;
        logic wr1_n;
        logic [NCS_W-1:0] cs_n;
        logic cke;
        logic wait_s1;
        logic wait_s2;
        logic nand_en;
        logic card1_en;
        logic card2_en;
        logic pullup_en;
        logic vsel;
        logic [31:0] prdata;
        logic pslverr;
        logic pready;
    } top_s;

    top_s q, d;

    always_comb
    begin
        d = q;
        d.addr = route_addr;
        d.a10 = route_a10;
        d.wr1_n = route_wr1_n;
        // Chip selects: the static controller drives all eight, except line 1 when DRAM owns it.
        d.cs_n = SMC_CS_N;
        d.cs_n[ext_bus_pkg::CS1_IDX] = csa[ext_bus_pkg::CS1_BIT] ? DRAM_CS_N
                                                                 : SMC_CS_N[ext_bus_pkg::CS1_IDX];
        d.cke = DRAM_CLOCK_ENABLE_IN;
        d.wait_s1 = EXTERNAL_WAIT_N;
        d.wait_s2 = q.wait_s1;
        d.nand_en = csa[ext_bus_pkg::CS3_BIT];
        d.card1_en = csa[ext_bus_pkg::CS4_BIT];
        d.card2_en = csa[ext_bus_pkg::CS5_BIT];
        d.pullup_en = !csa[ext_bus_pkg::PULLUP_BIT];
        d.vsel = csa[ext_bus_pkg::VSEL_BIT];
        // Read data and error are captured at the setup edge so they stand with ready, not one cycle later.
        if (PSEL && !PENABLE)
        begin
            d.prdata = (PADDR == ext_bus_pkg::CSA_OFFSET) ? csa : ext_bus_pkg::ZERO32;
            d.pslverr = (PADDR != ext_bus_pkg::CSA_OFFSET);
        end
        // Ready follows the setup cycle, so every access takes exactly one wait-free access phase.
        d.pready = PSEL && !PENABLE;
    end

    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            q.addr <= '0;
            q.a10 <= 1'b0;
            q.wr1_n <= 1'b1;
            q.cs_n <= '1;
            q.cke <= 1'b0;
            q.wait_s1 <= 1'b1;
            q.wait_s2 <= 1'b1;
            q.nand_en <= 1'b0;
            q.card1_en <= 1'b0;
            q.card2_en <= 1'b0;
            q.pullup_en <= 1'b1;
            q.vsel <= 1'b1;
            q.prdata <= ext_bus_pkg::ZERO32;
            q.pslverr <= 1'b0;
            q.pready <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ADDR_PINS = q.addr;
    assign DRAM_ADDRESS10_PIN = q.a10;
    assign WRITE_STROBE1_N = q.wr1_n;
    assign CHIP_SELECT_LINES_N = q.cs_n;
    assign DRAM_CLOCK_ENABLE = q.cke;
    assign WAIT_TO_SMC_N = q.wait_s2;
    assign CS3_NAND_LOGIC_ENABLE = q.nand_en;
    assign CS4_CARD_SLOT1_ENABLE = q.card1_en;
    assign CS5_CARD_SLOT2_ENABLE = q.card2_en;
    assign DATA_PULLUP_ENABLE = q.pullup_en;
    assign MEMORY_VOLTAGE_SELECT = q.vsel;
    assign PRDATA = q.prdata;
    assign PSLVERR = q.pslverr;
    assign PREADY = q.pready;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_cs1_dram_owner: assert property (@(posedge MCLK) disable iff (!RSTN)
        csa[ext_bus_pkg::CS1_BIT] |=> CHIP_SELECT_LINES_N[ext_bus_pkg::CS1_IDX] == $past(DRAM_CS_N))
        else $error("cs1 not from dram");
    a_cs1_static_owner: assert property (@(posedge MCLK) disable iff (!RSTN)
        !csa[ext_bus_pkg::CS1_BIT] |=> CHIP_SELECT_LINES_N[ext_bus_pkg::CS1_IDX] == $past(SMC_CS_N[1]))
        else $error("cs1 not from static");
    a_cs3_static: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> CHIP_SELECT_LINES_N[ext_bus_pkg::CS3_IDX] == $past(SMC_CS_N[3]))
        else $error("cs3 not static");
    a_nand_enable: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> CS3_NAND_LOGIC_ENABLE == $past(csa[ext_bus_pkg::CS3_BIT])) else $error("nand enable wrong");
    a_card_slots: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> CS4_CARD_SLOT1_ENABLE == $past(csa[ext_bus_pkg::CS4_BIT])
              && CS5_CARD_SLOT2_ENABLE == $past(csa[ext_bus_pkg::CS5_BIT])) else $error("card enable wrong");
    a_pullup_sense: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> DATA_PULLUP_ENABLE != $past(csa[ext_bus_pkg::PULLUP_BIT])) else $error("pullup inverted");
    a_voltage_out: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> MEMORY_VOLTAGE_SELECT == $past(csa[ext_bus_pkg::VSEL_BIT])) else $error("voltage wrong");
    a_reset_value: assert property (@(posedge MCLK)
        !RSTN |=> csa == ext_bus_pkg::CSA_RESET) else $error("reset value wrong");
    a_dram_addr_low: assert property (@(posedge MCLK) disable iff (!RSTN)
        dram_owns |=> ADDR_PINS[11:2] == $past(DRAM_ADDR[9:0]) && DRAM_ADDRESS10_PIN == $past(DRAM_ADDR[10]))
        else $error("dram address wrong");
    a_static_only: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> ADDR_PINS[1:0] == $past(SMC_ADDR[1:0]) && ADDR_PINS[12] == $past(SMC_ADDR[12])
              && ADDR_PINS[25:15] == $past(SMC_ADDR[25:15])) else $error("static-only pin wrong");
    a_wr1_route: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> WRITE_STROBE1_N == ($past(dram_owns) ? $past(DRAM_BYTE_MASK1_N) : $past(SMC_WRITE_STROBE1_N)))
        else $error("write strobe 1 wrong");
    a_static_addr: assert property (@(posedge MCLK) disable iff (!RSTN)
        !dram_owns |=> ADDR_PINS[14:2] == $past(SMC_ADDR[14:2])) else $error("static address wrong");
    a_apb_ready: assert property (@(posedge MCLK) disable iff (!RSTN)
        PSEL && !PENABLE |=> PREADY) else $error("no ready");

    c_dram_access: cover property (@(posedge MCLK) disable iff (!RSTN) dram_owns);
    c_nand_on: cover property (@(posedge MCLK) disable iff (!RSTN) CS3_NAND_LOGIC_ENABLE);
    c_low_voltage: cover property (@(posedge MCLK) disable iff (!RSTN) !MEMORY_VOLTAGE_SELECT);

endmodule : ext_bus_cs_assign_pin_mux

// *** ext_mem_model.sv ***
/*
 Far-side memory model: stretches an access by holding the wait pin low.
 Assumes the bench asks for a stretch with a one-cycle start pulse.
*/
module ext_mem_model
(
    // Clock
    input wire logic clk,
    // Stretch request
    input wire logic start,
    input wire logic [3:0] len,
    // Pin
    output logic wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    // The pin has a pull-up, so it rests high once released.
    assign wait_n = (cnt_q == 4'h0);
    always @(posedge clk)
    begin
        if (start)
            cnt_q <= len;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
endmodule : ext_mem_model

// *** testbench.sv ***
/*
 Self-checking bench for the chip-select assignment and pin multiplexer.
 Assumes zero-wait APB answers and pin outputs registered one edge late.
*/
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SMC_WRITE_STROBE1_N, SMC_ACTIVE, DRAM_CS_N;
    logic DRAM_BYTE_MASK1_N, DRAM_ACTIVE, DRAM_CLOCK_ENABLE_IN, EXTERNAL_WAIT_N, DRAM_ADDRESS10_PIN;
    logic WRITE_STROBE1_N, DRAM_CLOCK_ENABLE, WAIT_TO_SMC_N, CS3_NAND_LOGIC_ENABLE, CS4_CARD_SLOT1_ENABLE;
    logic CS5_CARD_SLOT2_ENABLE, DATA_PULLUP_ENABLE, MEMORY_VOLTAGE_SELECT, w_start, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [25:0] SMC_ADDR, ADDR_PINS;
    logic [7:0] SMC_CS_N, CHIP_SELECT_LINES_N;
    logic [12:0] DRAM_ADDR;
    logic [3:0] w_len;
    int num_errors = 0;
    int checked = 0;

    ext_bus_cs_assign_pin_mux uut (.*);
    ext_mem_model mem (.clk(MCLK), .start(w_start), .len(w_len), .wait_n(EXTERNAL_WAIT_N));

    // ----------------------------------------
    // Clock and bus tasks
    // ----------------------------------------
    initial
    begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        @(posedge MCLK);
        while (PREADY !== 1'b1 && n < 16)
        begin
            @(posedge MCLK);
            n++;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 16)
            num_errors++;
    endtask : apb

    // Outputs settle one edge after their cause, so look half a cycle past it.
    task automatic settle();
        @(posedge MCLK);
        @(negedge MCLK);
    endtask : settle

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        @(negedge MCLK);
        `CHK("cs", 8'hFF, CHIP_SELECT_LINES_N)
        `CHK("pullup", 1'b1, DATA_PULLUP_ENABLE)
        `CHK("vsel", 1'b1, MEMORY_VOLTAGE_SELECT)
        `CHK("nand", 1'b0, CS3_NAND_LOGIC_ENABLE)
        apb(1'b0, 12'h11C, 32'h00000000);
        `CHK("reset value", 32'h00010000, rd)
    endtask : t_reset

    task automatic t_regs();
        apb(1'b1, 12'h11C, 32'hFFFFFFFF);
        `CHK("wr err", 1'b0, err)
        apb(1'b1, 12'h120, 32'h00000000);
        `CHK("bad wr err", 1'b1, err)
        apb(1'b0, 12'h120, 32'hFFFFFFFF);
        `CHK("bad rd", 32'h00000000, rd)
        apb(1'b0, 12'h11C, 32'h00000000);
        `CHK("readback", 32'h0001013A, rd)
    endtask : t_regs

    task automatic t_cfg();
        logic [31:0] v [6] = '{32'h00000008, 32'h00000010, 32'h00000020, 32'h00000100, 32'h00010000, 32'h00000000};
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 12'h11C, v[i]);
            settle();
            `CHK("nand", v[i][3], CS3_NAND_LOGIC_ENABLE)
            `CHK("slot1", v[i][4], CS4_CARD_SLOT1_ENABLE)
            `CHK("slot2", v[i][5], CS5_CARD_SLOT2_ENABLE)
            `CHK("pullup", ~v[i][8], DATA_PULLUP_ENABLE)
            `CHK("vsel", v[i][16], MEMORY_VOLTAGE_SELECT)
        end
    endtask : t_cfg

    task automatic t_route();
        logic b1;
        logic dr;
        logic [25:0] ea;
        for (int k = 1; k < 4; k++)
        begin
            b1 = k[1];
            dr = k[1] & k[0];
            apb(1'b1, 12'h11C, {30'h00000000, b1, 1'b0});
            DRAM_ACTIVE <= k[0];
            settle();
            ea = dr ? {SMC_ADDR[25:15], DRAM_ADDR[12:11], SMC_ADDR[12], DRAM_ADDR[9:0], SMC_ADDR[1:0]} : SMC_ADDR;
            `CHK("addr", ea, ADDR_PINS)
            `CHK("a10", dr ? DRAM_ADDR[10] : 1'b0, DRAM_ADDRESS10_PIN)
            `CHK("wr1", dr ? DRAM_BYTE_MASK1_N : SMC_WRITE_STROBE1_N, WRITE_STROBE1_N)
            `CHK("cs", b1 ? {SMC_CS_N[7:2], DRAM_CS_N, SMC_CS_N[0]} : SMC_CS_N, CHIP_SELECT_LINES_N)
            `CHK("cke", DRAM_CLOCK_ENABLE_IN, DRAM_CLOCK_ENABLE)
        end
    endtask : t_route

    task automatic t_wait();
        @(posedge MCLK);
        w_len <= 4'h3;
        w_start <= 1'b1;
        @(posedge MCLK);
        w_start <= 1'b0;
        @(negedge MCLK);
        `CHK("wait pin", 1'b0, EXTERNAL_WAIT_N)
        @(negedge MCLK);
        `CHK("wait early", 1'b1, WAIT_TO_SMC_N)
        @(negedge MCLK);
        `CHK("wait sync", 1'b0, WAIT_TO_SMC_N)
    endtask : t_wait

    // ----------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    initial
    begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, DRAM_ACTIVE, w_start, w_len} = '0;
        {SMC_WRITE_STROBE1_N, SMC_ACTIVE, DRAM_CS_N, DRAM_BYTE_MASK1_N, DRAM_CLOCK_ENABLE_IN} = 5'b01111;
        SMC_ADDR = 26'h2ABCDEF;
        SMC_CS_N = 8'hA5;
        DRAM_ADDR = 13'h1555;
        RSTN = 1'b0;
        repeat (3) @(posedge MCLK);
        RSTN <= 1'b1;
        t_reset();
        t_regs();
        t_cfg();
        t_route();
        t_wait();
        end_sim();
    end

    initial
    begin
        repeat (5000) @(posedge MCLK);
        num_errors++;
        end_sim();
    end
endmodule : testbench
